/* hw/rsm_map.svh */
// Purpose: Register map constants for regulator slot/mode control
// Assumes: AXI4-Lite byte address = 4 x register index
// Notes:   Offsets, address width, fields, write masks, reset values, voltage constants, knee code and response codes only
`ifndef RSM_MAP_SVH
`define RSM_MAP_SVH
// ----------------------------------------
// Register indices and address width
// ----------------------------------------
`define RSM_IDX_REG7_SLEEP   16'h407C
`define RSM_IDX_REG8_CTRL    16'h407D
`define RSM_IDX_REG8_ON      16'h407E
`define RSM_IDX_REG8_SLEEP   16'h407F
`define RSM_IDX_IRQ_STATUS   16'h4090
`define RSM_IDX_IRQ_MASK     16'h4091
`define RSM_IDX_STATE        16'h4092
`define RSM_ADDR_W           18
// ----------------------------------------
// Writable bit masks and reset values
// ----------------------------------------
`define RSM_SLEEP_WMASK      16'hE11F
`define RSM_CTRL_WMASK       16'hDFC0
`define RSM_ON_WMASK         16'hE11F
`define RSM_REG7_SLEEP_RST   16'h0100
`define RSM_REG8_CTRL_RST    16'h0200
`define RSM_REG8_ON_RST      16'h0000
`define RSM_REG8_SLEEP_RST   16'h0100
// ----------------------------------------
// Field positions
// ----------------------------------------
`define RSM_SLOT_HI          15
`define RSM_SLOT_LO          13
`define RSM_MODE_BIT         8
`define RSM_VSEL_HI          4
`define RSM_VSEL_LO          0
`define RSM_ACT_HI           15
`define RSM_ACT_LO           14
`define RSM_SRC_HI           12
`define RSM_SRC_LO           11
`define RSM_HWV_BIT          10
`define RSM_HWM_HI           9
`define RSM_HWM_LO           8
`define RSM_FLT_BIT          7
`define RSM_SWI_BIT          6
// ----------------------------------------
// Voltage code constants (mV), knee code and AXI response codes
// ----------------------------------------
`define RSM_MV_BASE          12'd1000
`define RSM_MV_FINE          12'd50
`define RSM_MV_COARSE        12'd100
`define RSM_MV_KNEE          12'd1700
`define RSM_KNEE_CODE        5'h0D
`define RSM_RESP_OKAY        2'b00
`define RSM_RESP_SLVERR      2'b10
`endif

/* hw/rsm_pkg.sv */
// Purpose: Types for regulator slot/mode control
// Assumes: Constants live in rsm_map.svh
// Notes:   Packed carriers for regulator outputs
package rsm_pkg;
  typedef enum logic [1:0] {
    RSM_ACT_IGNORE   = 2'b00,
    RSM_ACT_REG_OFF  = 2'b01,
    RSM_ACT_SYS_RST  = 2'b10,
    RSM_ACT_RESERVED = 2'b11
  } rsm_action_t;
  typedef enum logic [1:0] {
    RSM_WR_IDLE = 2'b00,
    RSM_WR_RESP = 2'b01
  } rsm_wr_state_t;
  typedef struct packed {
    logic        enabled;
    logic        low_power;
    logic [11:0] millivolts;
    logic        float_off;
    logic        switch_mode;
  } rsm_reg_out_t;
endpackage : rsm_pkg

/* hw/rsm_top.sv */
// Purpose: Control registers and output steering for two linear regulators
// Assumes: Sequencer gives a timeslot number and sleep/start phase
// Notes:   Single clock, synchronous reset, AXI4-Lite slave
//
// How it works
// - Sleep slot 000 moves regulator 7 to sleep voltage and mode in timeslot five.
// - Sleep slot 001..101 disable regulator 7 in timeslots five down to one.
// - Sleep slot 110 transitions in timeslot three, 111 in timeslot one.
// - Under a hardware enable, codes 001..101 pick the slot for entering sleep instead.
// - Sleep mode bit of regulator 7 is normal at 0, low power at 1, reset 1.
// - Regulator 7 sleep code maps 1.00V..1.60V in 50mV then 1.70V..3.50V in 100mV.
// - Undervoltage action of regulator 8: ignore, shut regulator, device reset, reserved.
// - Any regulator 8 undervoltage sets interrupt status bit 0; irq follows unless that bit is masked.
// - Hardware control source: none, input one, input two, or either.
// - Under hardware control, voltage is the on code or the sleep code per select bit.
// - Hardware mode field: 00/10 low power, 01 off, 11 follows on mode; resets to 10.
// - Float bit chooses discharge or float when off; switch bit chooses linear or switch.
// - On slot: 000 never, 001..101 timeslots one to five, 110/111 hardware enable one/two.
// - On mode bit of regulator 8 is normal at 0, low power at 1, reset 0.
// - Regulator 8 on code uses the same voltage mapping as the sleep code.
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "rsm_map.svh"
module rsm_top (
  // Clock and reset
  input  wire logic                     clk_sys,
  input  wire logic                     sys_rst,
  // AXI4-Lite write
  input  wire logic [`RSM_ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  // AXI4-Lite read
  input  wire logic [`RSM_ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  // Sequencer and hardware inputs
  input  wire logic [2:0]               timeslot,
  input  wire logic                     slot_strobe,
  input  wire logic                     seq_sleep,
  input  wire logic                     seq_start,
  input  wire logic                     hw_enable1,
  input  wire logic                     hw_enable2,
  input  wire logic                     hw_control1,
  input  wire logic                     hw_control2,
  input  wire logic                     reg8_undervoltage,
  // Regulator outputs
  output rsm_pkg::rsm_reg_out_t         reg7_out,
  output rsm_pkg::rsm_reg_out_t         reg8_out,
  output logic                          reg8_uv_shutdown,
  output logic                          device_reset_req,
  output logic                          irq
);
  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  logic [15:0] reg7_sleep_control;
  logic [15:0] reg8_control;
  logic [15:0] reg8_on_control;
  logic [15:0] reg8_sleep_control;
  logic [1:0]  irq_status;
  logic [1:0]  irq_mask;
  logic        reg7_in_sleep;
  logic        reg7_off;
  logic        reg8_seq_on;
  logic        uv_prev;
  logic        uv_latched;

  // ----------------------------------------
  // Field views
  // ----------------------------------------
  wire [2:0] reg7_sleep_timeslot     = reg7_sleep_control[`RSM_SLOT_HI:`RSM_SLOT_LO];
  wire       reg7_sleep_power_mode   = reg7_sleep_control[`RSM_MODE_BIT];
  wire [4:0] reg7_sleep_voltage_code = reg7_sleep_control[`RSM_VSEL_HI:`RSM_VSEL_LO];
  wire [1:0] reg8_undervoltage_action = reg8_control[`RSM_ACT_HI:`RSM_ACT_LO];
  wire [1:0] reg8_hw_control_source  = reg8_control[`RSM_SRC_HI:`RSM_SRC_LO];
  wire       reg8_hw_voltage_choice  = reg8_control[`RSM_HWV_BIT];
  wire [1:0] reg8_hw_power_mode      = reg8_control[`RSM_HWM_HI:`RSM_HWM_LO];
  wire       reg8_output_float       = reg8_control[`RSM_FLT_BIT];
  wire       reg8_switch_operation   = reg8_control[`RSM_SWI_BIT];
  wire [2:0] reg8_on_timeslot        = reg8_on_control[`RSM_SLOT_HI:`RSM_SLOT_LO];
  wire       reg8_on_power_mode      = reg8_on_control[`RSM_MODE_BIT];
  wire [4:0] reg8_on_voltage_code    = reg8_on_control[`RSM_VSEL_HI:`RSM_VSEL_LO];
  wire [4:0] reg8_sleep_voltage_code = reg8_sleep_control[`RSM_VSEL_HI:`RSM_VSEL_LO];

  // ----------------------------------------
  // Voltage code to millivolts
  // ----------------------------------------
  function automatic logic [11:0] code_to_mv(input logic [4:0] code);
    logic [11:0] c;
    c = {7'h00, code};
    if (code < `RSM_KNEE_CODE)
      code_to_mv = 12'(`RSM_MV_BASE + c * `RSM_MV_FINE);
    else
      code_to_mv = 12'(`RSM_MV_KNEE + (c - 12'h00D) * `RSM_MV_COARSE);
  endfunction : code_to_mv

  // ----------------------------------------
  // Regulator 7 sleep sequencing
  // ----------------------------------------
  // Slot number the sleep code acts in; code 0 acts in slot five
  wire [2:0] r7_slot =
    (reg7_sleep_timeslot == 3'h0) ? 3'h5 :
    (reg7_sleep_timeslot == 3'h6) ? 3'h3 :
    (reg7_sleep_timeslot == 3'h7) ? 3'h1 :
    3'(3'h6 - reg7_sleep_timeslot);
  wire r7_disables  = (reg7_sleep_timeslot != 3'h0) && (reg7_sleep_timeslot < 3'h6);
  wire r7_hit       = slot_strobe && seq_sleep && (timeslot == r7_slot);
  // Hardware-enable mode turns a disable slot into a sleep entry
  wire r7_hw_owned  = hw_enable1 | hw_enable2;
  wire next_r7_off  = r7_hit && r7_disables && !r7_hw_owned;
  wire next_r7_slp  = r7_hit && (!r7_disables || r7_hw_owned);

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      reg7_in_sleep <= 1'b0;
      reg7_off      <= 1'b0;
    end else if (slot_strobe && seq_start) begin
      reg7_in_sleep <= 1'b0;
      reg7_off      <= 1'b0;
    end else begin
      if (next_r7_slp)
        reg7_in_sleep <= 1'b1;
      if (next_r7_off)
        reg7_off <= 1'b1;
    end
  end

  // ----------------------------------------
  // Regulator 8 enable and hardware control
  // ----------------------------------------
  wire r8_hw_enable_sel = reg8_on_timeslot[2] & reg8_on_timeslot[1];
  wire r8_hw_enable     = reg8_on_timeslot[0] ? hw_enable2 : hw_enable1;
  wire r8_slot_hit      = slot_strobe && seq_start && (reg8_on_timeslot != 3'h0)
                          && !r8_hw_enable_sel && (timeslot == reg8_on_timeslot);
  wire r8_hwc =
    (reg8_hw_control_source == 2'b01) ? hw_control1 :
    (reg8_hw_control_source == 2'b10) ? hw_control2 :
    (reg8_hw_control_source == 2'b11) ? (hw_control1 | hw_control2) : 1'b0;
  wire r8_base_on = r8_hw_enable_sel ? r8_hw_enable : reg8_seq_on;
  wire r8_hw_off  = r8_hwc && (reg8_hw_power_mode == 2'b01);
  wire r8_lp      = r8_hwc ? ((reg8_hw_power_mode == 2'b11) ? reg8_on_power_mode : 1'b1)
                           : reg8_on_power_mode;
  wire [4:0] r8_code = (r8_hwc && reg8_hw_voltage_choice) ? reg8_sleep_voltage_code
                                                          : reg8_on_voltage_code;

  // Undervoltage rising edge
  wire uv_event = reg8_undervoltage && !uv_prev;
  wire uv_act_reg = uv_event &&
    (rsm_pkg::rsm_action_t'(reg8_undervoltage_action) == rsm_pkg::RSM_ACT_REG_OFF);
  wire uv_act_sys = uv_event &&
    (rsm_pkg::rsm_action_t'(reg8_undervoltage_action) == rsm_pkg::RSM_ACT_SYS_RST);

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      reg8_seq_on <= 1'b0;
      uv_prev     <= 1'b0;
      uv_latched  <= 1'b0;
    end else begin
      uv_prev <= reg8_undervoltage;
      if (uv_act_reg)
        uv_latched <= 1'b1;
      else if (slot_strobe && seq_start)
        uv_latched <= 1'b0;
      if (r8_slot_hit)
        reg8_seq_on <= 1'b1;
      else if (slot_strobe && seq_sleep && timeslot == 3'h1)
        reg8_seq_on <= 1'b0;
    end
  end

  // ----------------------------------------
  // Output registers
  // ----------------------------------------
  rsm_pkg::rsm_reg_out_t next_reg7_out;
  rsm_pkg::rsm_reg_out_t next_reg8_out;
  assign next_reg7_out = '{
    enabled:     !reg7_off,
    low_power:   reg7_in_sleep & reg7_sleep_power_mode,
    millivolts:  reg7_in_sleep ? code_to_mv(reg7_sleep_voltage_code) : `RSM_MV_BASE,
    float_off:   1'b0,
    switch_mode: 1'b0
  };
  assign next_reg8_out = '{
    enabled:     r8_base_on && !r8_hw_off && !uv_latched,
    low_power:   r8_lp,
    millivolts:  code_to_mv(r8_code),
    float_off:   reg8_output_float,
    switch_mode: reg8_switch_operation
  };

  // ----------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------
  logic                  aw_held;
  logic                  w_held;
  logic [`RSM_ADDR_W-1:0] aw_addr;
  logic [31:0]           w_data;
  logic [3:0]            w_strb;
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take  = s_axi_wvalid && s_axi_wready;
  wire [`RSM_ADDR_W-1:0] wr_addr = aw_take ? s_axi_awaddr : aw_addr;
  wire [31:0]            wr_data = w_take ? s_axi_wdata : w_data;
  wire [3:0]             wr_strb = w_take ? s_axi_wstrb : w_strb;
  wire wr_fire = (aw_held || aw_take) && (w_held || w_take) && !s_axi_bvalid;
  wire [15:0] wr_idx = wr_addr[17:2];
  wire [15:0] wr_lane = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};
  wire wr_hit = (wr_idx == `RSM_IDX_REG7_SLEEP) || (wr_idx == `RSM_IDX_REG8_CTRL) ||
                (wr_idx == `RSM_IDX_REG8_ON) || (wr_idx == `RSM_IDX_REG8_SLEEP) ||
                (wr_idx == `RSM_IDX_IRQ_STATUS) || (wr_idx == `RSM_IDX_IRQ_MASK) ||
                (wr_idx == `RSM_IDX_STATE);

  // Merge byte lanes, keep reserved bits zero
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wmask,
                                        input logic [15:0] data, input logic [15:0] lanes);
    merge = ((old & ~lanes) | (data & lanes)) & wmask;
  endfunction : merge

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= '0;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RSM_RESP_OKAY;
    end else begin
      if (aw_take && !wr_fire) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (w_take && !wr_fire) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `RSM_RESP_OKAY : `RSM_RESP_SLVERR;
      end else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;

  // ----------------------------------------
  // Register file and interrupt
  // ----------------------------------------
  wire rd_fire = s_axi_arvalid && s_axi_arready;
  wire [15:0] rd_idx = s_axi_araddr[17:2];
  wire status_read = rd_fire && (rd_idx == `RSM_IDX_IRQ_STATUS);
  // Bit0 undervoltage, bit1 undervoltage action taken
  wire [1:0] irq_set = {uv_act_reg | uv_act_sys, uv_event};

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      reg7_sleep_control <= `RSM_REG7_SLEEP_RST;
      reg8_control       <= `RSM_REG8_CTRL_RST;
      reg8_on_control    <= `RSM_REG8_ON_RST;
      reg8_sleep_control <= `RSM_REG8_SLEEP_RST;
      irq_mask           <= 2'b00;
    end else if (wr_fire) begin
      if (wr_idx == `RSM_IDX_REG7_SLEEP)
        reg7_sleep_control <= merge(reg7_sleep_control, `RSM_SLEEP_WMASK, wr_data[15:0], wr_lane);
      if (wr_idx == `RSM_IDX_REG8_CTRL)
        reg8_control <= merge(reg8_control, `RSM_CTRL_WMASK, wr_data[15:0], wr_lane);
      if (wr_idx == `RSM_IDX_REG8_ON)
        reg8_on_control <= merge(reg8_on_control, `RSM_ON_WMASK, wr_data[15:0], wr_lane);
      if (wr_idx == `RSM_IDX_REG8_SLEEP)
        reg8_sleep_control <= merge(reg8_sleep_control, `RSM_SLEEP_WMASK, wr_data[15:0], wr_lane);
      if (wr_idx == `RSM_IDX_IRQ_MASK && wr_strb[0])
        irq_mask <= wr_data[1:0];
    end
  end

  // Set wins over read-clear
  always_ff @(posedge clk_sys) begin
    if (sys_rst)
      irq_status <= 2'b00;
    else
      irq_status <= (status_read ? 2'b00 : irq_status) | irq_set;
  end

  wire [15:0] state_word = {11'h000, uv_latched, reg8_seq_on, reg7_off, reg7_in_sleep, r8_hwc};
  wire [15:0] rd_word =
    (rd_idx == `RSM_IDX_REG7_SLEEP) ? reg7_sleep_control :
    (rd_idx == `RSM_IDX_REG8_CTRL)  ? reg8_control :
    (rd_idx == `RSM_IDX_REG8_ON)    ? reg8_on_control :
    (rd_idx == `RSM_IDX_REG8_SLEEP) ? reg8_sleep_control :
    (rd_idx == `RSM_IDX_IRQ_STATUS) ? {14'h0000, irq_status} :
    (rd_idx == `RSM_IDX_IRQ_MASK)   ? {14'h0000, irq_mask} :
    (rd_idx == `RSM_IDX_STATE)      ? state_word : 16'h0000;
  wire rd_hit = (rd_idx == `RSM_IDX_REG7_SLEEP) || (rd_idx == `RSM_IDX_REG8_CTRL) ||
                (rd_idx == `RSM_IDX_REG8_ON) || (rd_idx == `RSM_IDX_REG8_SLEEP) ||
                (rd_idx == `RSM_IDX_IRQ_STATUS) || (rd_idx == `RSM_IDX_IRQ_MASK) ||
                (rd_idx == `RSM_IDX_STATE);
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `RSM_RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {16'h0000, rd_word};
      s_axi_rresp  <= rd_hit ? `RSM_RESP_OKAY : `RSM_RESP_SLVERR;
    end else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      reg7_out         <= '0;
      reg8_out         <= '0;
      reg8_uv_shutdown <= 1'b0;
      device_reset_req <= 1'b0;
      irq              <= 1'b0;
    end else begin
      reg7_out         <= next_reg7_out;
      reg8_out         <= next_reg8_out;
      reg8_uv_shutdown <= uv_latched;
      device_reset_req <= uv_act_sys;
      irq              <= |(irq_status & ~irq_mask);
    end
  end
endmodule : rsm_top

/* test/rsm_top_monitor.sv */
// Purpose: Port-level checks for rsm_top
// Assumes: Single clock domain, synchronous active-high reset
// Notes:   Attached by bind; watches bus handshakes and outputs
`timescale 1ns/1ns
module rsm_top_chk (
  // Clock and reset
  input wire logic                  clk_sys,
  input wire logic                  sys_rst,
  // Bus handshakes
  input wire logic                  s_axi_awvalid,
  input wire logic                  s_axi_awready,
  input wire logic                  s_axi_wvalid,
  input wire logic                  s_axi_wready,
  input wire logic                  s_axi_bvalid,
  input wire logic                  s_axi_bready,
  input wire logic                  s_axi_arvalid,
  input wire logic                  s_axi_arready,
  input wire logic                  s_axi_rvalid,
  input wire logic                  s_axi_rready,
  input wire logic [31:0]           s_axi_rdata,
  // Regulator side
  input wire rsm_pkg::rsm_reg_out_t reg8_out,
  input wire logic                  device_reset_req
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // ----------------------------------------
  // Bus sequences
  // ----------------------------------------
  sequence wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  wr_answer_a: assert property (wr_both |=> s_axi_bvalid) else $error("write response missing");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
  aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken early");
  rd_answer_a: assert property (rd_taken |=> s_axi_rvalid) else $error("read data missing");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  rd_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read bits set");
  reset_pulse_a: assert property (device_reset_req |=> !device_reset_req)
    else $error("device reset not a pulse");
  volt_range_a: assert property (reg8_out.enabled |-> reg8_out.millivolts inside {[12'd1000:12'd3500]})
    else $error("voltage out of range");
endmodule : rsm_top_chk

bind rsm_top rsm_top_chk u_chk (.clk_sys, .sys_rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .reg8_out, .device_reset_req);

/* test/rsm_top_tb.sv */
// Purpose: Self-checking bench for rsm_top
// Assumes: Byte address is four times the register index
// Notes:   Mask bit set hides its status bit
`timescale 1ns/1ns
`include "rsm_map.svh"
module rsm_top_tb;
  localparam logic [17:0] A7 = {`RSM_IDX_REG7_SLEEP, 2'b00};
  localparam logic [17:0] A8C = {`RSM_IDX_REG8_CTRL, 2'b00};
  localparam logic [17:0] A8O = {`RSM_IDX_REG8_ON, 2'b00};
  localparam logic [17:0] AST = {`RSM_IDX_IRQ_STATUS, 2'b00};
  localparam logic [17:0] AMK = {`RSM_IDX_IRQ_MASK, 2'b00};
  logic clk_sys = 1'b0, sys_rst = 1'b1;
  logic [17:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [2:0] timeslot = 3'h0;
  logic slot_strobe = 1'b0, seq_sleep = 1'b0, seq_start = 1'b0, hw_enable1 = 1'b0, hw_enable2 = 1'b0;
  logic hw_control1 = 1'b0, hw_control2 = 1'b0, reg8_undervoltage = 1'b0;
  logic reg8_uv_shutdown, device_reset_req, irq;
  rsm_pkg::rsm_reg_out_t reg7_out, reg8_out;
  int err_count = 0, n_checks = 0, cyc = 0;

  always #20 clk_sys = ~clk_sys;

  rsm_top DUT (.clk_sys, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .timeslot, .slot_strobe,
    .seq_sleep, .seq_start, .hw_enable1, .hw_enable2, .hw_control1, .hw_control2, .reg8_undervoltage,
    .reg7_out, .reg8_out, .reg8_uv_shutdown, .device_reset_req, .irq);

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic close_out();
    $display("checks=%0d mismatches=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic axi_wr(input logic [17:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk_sys);
      if (!aw_ok && s_axi_awready === 1'b1) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready === 1'b1) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clk_sys); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [17:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk_sys); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk_sys); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd

  task automatic wr(input logic [17:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
  endtask : wr

  task automatic rd(input logic [17:0] a, output logic [31:0] d);
    logic [1:0] r;
    axi_rd(a, d, r);
  endtask : rd

  // Slot effects take two registered steps, so allow three edges
  task automatic strobe(input logic [2:0] ts);
    @(posedge clk_sys);
    timeslot <= ts;
    slot_strobe <= 1'b1;
    @(posedge clk_sys);
    slot_strobe <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask : strobe

  task automatic restart();
    seq_sleep <= 1'b0;
    seq_start <= 1'b1;
    strobe(3'd2);
    seq_start <= 1'b0;
    seq_sleep <= 1'b1;
  endtask : restart

  task automatic uv_event(output int n);
    n = 0;
    @(posedge clk_sys);
    reg8_undervoltage <= 1'b1;
    repeat (6) begin
      @(posedge clk_sys);
      n += int'(device_reset_req === 1'b1);
    end
    reg8_undervoltage <= 1'b0;
  endtask : uv_event

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    rd(A7, d); chk(d, 32'h0000_0100);
    rd(A8C, d); chk(d, 32'h0000_0200);
    rd(A8O, d); chk(d, 32'h0000_0000);
    wr(A7, 32'hFFFF_FFFF);
    wr(A8C, 32'hFFFF_FFFF);
    wr(A8O, 32'hFFFF_FFFF);
    rd(A7, d); chk(d, 32'h0000_E11F);
    rd(A8C, d); chk(d, 32'h0000_DFC0);
    rd(A8O, d); chk(d, 32'h0000_E11F);
    axi_wr(18'h10200, 32'h1, r); chk(r, 32'h2);
    axi_rd(18'h10200, d, r); chk({d[29:0], r}, 32'h2);
  endtask : t_regs

  task automatic t_sleep();
    wr(A7, 32'h0000_010D); // slot code 000, low power, 1.70 V
    seq_sleep <= 1'b1;
    strobe(3'd5);
    chk(reg7_out.enabled, 1);
    chk(reg7_out.low_power, 1);
    chk(reg7_out.millivolts, 1700);
    wr(A7, 32'h0000_2000); // slot code 001
    strobe(3'd4);
    chk(reg7_out.enabled, 1);
    strobe(3'd5);
    chk(reg7_out.enabled, 0);
    restart();
    chk(reg7_out.enabled, 1);
    wr(A7, 32'h0000_C10D); // slot code 110
    strobe(3'd5);
    chk(reg7_out.low_power, 0);
    strobe(3'd3);
    chk(reg7_out.low_power, 1);
    restart();
    wr(A7, 32'h0000_E10D); // slot code 111
    strobe(3'd1);
    chk(reg7_out.low_power, 1);
    restart();
    hw_enable1 <= 1'b1;
    wr(A7, 32'h0000_210D); // slot code 001 under a hardware enable
    strobe(3'd5);
    chk({reg7_out.enabled, reg7_out.low_power}, 2'b11);
    hw_enable1 <= 1'b0;
    seq_sleep <= 1'b0;
  endtask : t_sleep

  task automatic t_volt();
    logic [4:0] codes [5] = '{5'h00, 5'h01, 5'h0C, 5'h0D, 5'h1F};
    int mv;
    seq_start <= 1'b1;
    wr(A8O, 32'h0000_2000); // enable in slot one
    strobe(3'd1);
    chk(reg8_out.enabled, 1);
    foreach (codes[i]) begin
      mv = codes[i] < 13 ? 1000 + 50 * codes[i] : 1700 + 100 * (codes[i] - 13);
      wr(A8O, {16'h0, 11'h109, codes[i]});
      repeat (2) @(posedge clk_sys);
      chk(reg8_out.millivolts, mv);
      chk(reg8_out.low_power, 1);
    end
    chk({reg8_out.float_off, reg8_out.switch_mode}, 2'b11);
    hw_control2 <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk(reg8_out.millivolts, 1000);
    chk(reg8_out.low_power, 1);
    wr(A8C, 32'h0000_1900); // either input acts, off under control
    repeat (2) @(posedge clk_sys);
    chk({reg8_out.enabled, reg8_out.millivolts}, {1'b0, 12'd3500});
    wr(A8C, 32'h0000_0900); // input one only
    repeat (2) @(posedge clk_sys);
    chk(reg8_out.enabled, 1);
    wr(A8O, 32'h0000_E000); // enable handed to hardware input two
    hw_enable1 <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk(reg8_out.enabled, 0);
    hw_control2 <= 1'b0;
    hw_enable1 <= 1'b0;
    seq_start <= 1'b0;
  endtask : t_volt

  task automatic t_uv();
    logic [31:0] d;
    int n;
    wr(AMK, 32'h0);
    wr(A8C, 32'h0000_4200); // shut regulator down
    uv_event(n);
    chk(n, 0);
    chk(reg8_uv_shutdown, 1);
    chk(irq, 1);
    rd(AST, d); chk(d[0], 1);
    repeat (2) @(posedge clk_sys);
    chk(irq, 0);
    wr(AMK, 32'h3);
    wr(A8C, 32'h0000_8200); // device reset
    uv_event(n);
    chk(n, 1);
    chk(irq, 0);
    rd(AST, d); chk(d[0], 1);
  endtask : t_uv

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      close_out();
    end
  end

  initial begin
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_regs();
    t_sleep();
    t_volt();
    t_uv();
    close_out();
  end
endmodule : rsm_top_tb
